// file: pkg/eesg_defines.svh
// constants for the enclave extended-state guard
`ifndef EESG_DEFINES_SVH
`define EESG_DEFINES_SVH
`define EESG_MASK_W         64
`define EESG_MASK_LEGACY    64'h0000000000000003
`define EESG_MASK_LOW_ALL   2'h3
`define EESG_MASK_TOP_BIT   63
`define EESG_XCR_RESET      64'h0000000000000003
`define EESG_FRAME_W        32
`define EESG_SSM_OFFSET     16'h7EE0
`define EESG_SSM_BIT        1
`define EESG_MISC_W         32
`define EESG_CTL_RST_W      7
`endif

// file: pkg/eesg_pkg.sv
// types for the enclave extended-state guard
package eesg_pkg;
  typedef enum logic [3:0] {
    EESG_OP_NONE,
    EESG_OP_CREATE,
    EESG_OP_ENTER,
    EESG_OP_RESUME,
    EESG_OP_LEAVE,
    EESG_OP_REPORT
  } eesg_op_t;
  typedef enum logic [1:0] {
    EESG_FAULT_NONE,
    EESG_FAULT_GP,
    EESG_FAULT_UD
  } eesg_fault_t;
  typedef enum {
    EESG_RUN,
    EESG_SAVE,
    EESG_SYNTH,
    EESG_HANDOFF
  } eesg_state_t;
endpackage

// file: logic/eesg_checks.sv
// combinational fault checks for create, enter and resume
`timescale 1ns/100ps
`include "eesg_defines.svh"
module eesg_checks
  import eesg_pkg::*;
(
  input  wire logic [63:0] mask,
  input  wire logic [63:0] xcr,
  input  wire logic        save_support,
  input  wire logic        fx_en,
  input  wire logic        ext_en,
  input  wire logic        xcr_load_bad,
  input  wire logic        frame_small,
  input  wire logic [31:0] frame_size,
  input  wire logic        area_bad,
  output logic             create_bad,
  output logic             entry_bad,
  output logic             resume_bad
);
  logic low_bad;
  logic legacy;
  // mask low two bits must both be one
  assign low_bad = mask[1:0] != `EESG_MASK_LOW_ALL;
  assign legacy  = mask == `EESG_MASK_LEGACY;
  // creation checks differ on cores without save support
  always_comb begin
    create_bad = low_bad;
    if (!save_support) begin
      create_bad = create_bad | (|mask[63:2]) |
                   (frame_size == '0);
    end else begin
      create_bad = create_bad | xcr_load_bad |
                   mask[`EESG_MASK_TOP_BIT] | frame_small;
    end
  end
  // entry checks; resume adds bad save-area content
  always_comb begin
    entry_bad = !fx_en;
    if (save_support) begin
      entry_bad = entry_bad | (!ext_en && !legacy) |
                  ((mask & xcr) != mask);
    end
    resume_bad = entry_bad | area_bad;
  end
endmodule

// file: logic/eesg_guard.sv
// enclave extended-state guard: op checks, register swap, async exits
`timescale 1ns/100ps
`include "eesg_defines.svh"
//
// Function
// - create faults with code zero unless mask low bits equal 3
// - without save support, create faults on upper mask bits or zero frame
// - with save support, create faults on bad load, bit 63, small frame
// - entry faults on fx disabled; with save support also on ext disabled non-legacy, mask not subset
// - resume applies the same fault conditions as entry
// - successful entry saves control register then loads mask
// - async exit saves state using mask as component bitmap
// - present bits outside mask are written zero on async exit
// - after save, restore control register and synthesize enabled state in the same cycle
// - resume faults on save area content a restore would reject
// - successful resume saves control register and loads mask
// - after resume the state in the requested mask is marked modified
// - leave does no checks, no synthesis, restores control register
// - report carries mask and misc select values
// - enclave instructions in management mode raise invalid opcode
// - management interrupt without dual monitor exits and sets map bit 1
// - with dual monitor, exit then monitor exit with interrupt flags
// - warm restart outside virtualization exits and reinitializes core
// - warm restart in virtualization root operation is blocked
// - warm restart in non-root exits then takes a VM exit
// - startup interrupt inside enclave discarded; enclave mode stays set
module eesg_guard
  import eesg_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        op_valid,
  input  wire eesg_op_t    op_code,
  input  wire logic        is_supervisor_insn,
  input  wire logic [63:0] requested_feature_mask,
  input  wire logic [31:0] misc_state_select,
  input  wire logic [31:0] save_frame_size,
  input  wire logic        frame_small,
  input  wire logic        xcr_load_bad,
  input  wire logic        area_bad,
  input  wire logic        save_support,
  input  wire logic        os_fx_save_enable,
  input  wire logic        os_ext_save_enable,
  input  wire logic        system_mgmt_mode,
  input  wire logic        dual_monitor,
  input  wire logic        vmx_root,
  input  wire logic        vmx_nonroot,
  input  wire logic        is_boot_core,
  input  wire logic        xcr_write,
  input  wire logic [63:0] xcr_write_data,
  input  wire logic        async_system_mgmt_interrupt,
  input  wire logic        async_warm_restart_signal,
  input  wire logic        async_startup_ipi,
  input  wire logic        save_state_modified,
  output logic             op_done,
  output eesg_fault_t      fault,
  output logic [15:0]      fault_code,
  output logic [63:0]      extended_control_reg,
  output logic             enclave_mode,
  output logic             save_pulse,
  output logic [63:0]      save_component_bitmap,
  output logic [63:0]      save_present_mask,
  output logic             save_wide_form,
  output logic             synth_pulse,
  output logic [63:0]      synth_bitmap,
  output logic [63:0]      modified_bitmap,
  output logic             report_valid,
  output logic [63:0]      report_feature_mask,
  output logic [31:0]      report_misc_select,
  output logic             mgmt_handler_go,
  output logic             ssm_interrupt_bit,
  output logic             monitor_exit,
  output logic             vm_exit,
  output logic             exit_enclave_flag,
  output logic             guest_enclave_flag,
  output logic             power_on_init,
  output logic             firmware_init,
  output logic             wait_for_startup,
  output logic             warm_restart_blocked,
  output logic             startup_dropped
);
  // ************************************************************
  // input synchronisers and internal state
  // ************************************************************
  logic [2:0]  sync_a;
  logic [2:0]  sync_b;
  logic [63:0] saved_xcr;
  logic [63:0] enc_mask;
  logic        enc_wide;
  logic        create_bad;
  logic        entry_bad;
  logic        resume_bad;
  logic        exit_smi;
  logic        exit_init;
  logic        ud_hit;
  eesg_state_t state;
  eesg_state_t next_state;

  // checks are pure logic so they settle before any register updates
  eesg_checks i_eesg_checks (
    .mask         (requested_feature_mask),
    .xcr          (extended_control_reg),
    .save_support (save_support),
    .fx_en        (os_fx_save_enable),
    .ext_en       (os_ext_save_enable),
    .xcr_load_bad (xcr_load_bad),
    .frame_small  (frame_small),
    .frame_size   (save_frame_size),
    .area_bad     (area_bad),
    .create_bad   (create_bad),
    .entry_bad    (entry_bad),
    .resume_bad   (resume_bad)
  );

  // two flops on each asynchronous event pin; only sync_b is read
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else if (clk_en) begin
      sync_a <= {async_startup_ipi, async_warm_restart_signal,
                 async_system_mgmt_interrupt};
      sync_b <= sync_a;
    end
  end

  function automatic logic is_enclave_op(input eesg_op_t op);
    is_enclave_op = op != EESG_OP_NONE;
  endfunction

  // management mode forbids every enclave instruction
  assign ud_hit = op_valid && is_enclave_op(op_code) &&
                  system_mgmt_mode && state == EESG_RUN;
  // warm restart in root operation stays blocked, so no exit then
  assign exit_smi  = enclave_mode && sync_b[0];
  assign exit_init = enclave_mode && sync_b[1] && !vmx_root;

  // ************************************************************
  // operation handling and register swap
  // ************************************************************
  // a fault leaves control register and mode untouched
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      op_done              <= 1'b0;
      fault                <= EESG_FAULT_NONE;
      fault_code           <= 16'h0000;
      extended_control_reg <= `EESG_XCR_RESET;
      saved_xcr            <= `EESG_XCR_RESET;
      enc_mask             <= `EESG_MASK_LEGACY;
      enc_wide             <= 1'b0;
      enclave_mode         <= 1'b0;
      report_valid         <= 1'b0;
      report_feature_mask  <= 64'h0000000000000000;
      report_misc_select   <= 32'h00000000;
    end else if (clk_en) begin
      op_done      <= 1'b0;
      fault        <= EESG_FAULT_NONE;
      fault_code   <= 16'h0000;
      report_valid <= 1'b0;
      if (state == EESG_SYNTH) begin
        extended_control_reg <= saved_xcr;
        enclave_mode         <= 1'b0;
      end else if (ud_hit) begin
        op_done <= 1'b1;
        fault   <= EESG_FAULT_UD;
      end else if (op_valid && state == EESG_RUN) begin
        op_done <= 1'b1;
        unique case (op_code)
          EESG_OP_CREATE: begin
            if (create_bad) begin
              fault <= EESG_FAULT_GP;
            end else begin
              enc_mask <= requested_feature_mask;
              enc_wide <= is_supervisor_insn;
            end
          end
          EESG_OP_ENTER, EESG_OP_RESUME: begin
            if ((op_code == EESG_OP_ENTER) ? entry_bad : resume_bad) begin
              fault <= EESG_FAULT_GP;
            end else begin
              saved_xcr            <= extended_control_reg;
              extended_control_reg <= requested_feature_mask;
              enc_mask             <= requested_feature_mask;
              enclave_mode         <= 1'b1;
            end
          end
          EESG_OP_LEAVE: begin
            if (enclave_mode) begin
              extended_control_reg <= saved_xcr;
              enclave_mode         <= 1'b0;
            end
          end
          EESG_OP_REPORT: begin
            report_valid        <= 1'b1;
            report_feature_mask <= enc_mask;
            report_misc_select  <= misc_state_select;
          end
          EESG_OP_NONE: begin
            op_done <= 1'b0;
          end
        endcase
      end else if (xcr_write && !enclave_mode) begin
        extended_control_reg <= xcr_write_data;
      end
    end
  end

  // ************************************************************
  // asynchronous exit sequencing
  // ************************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      EESG_RUN:     if (exit_smi || exit_init) next_state = EESG_SAVE;
      EESG_SAVE:    next_state = EESG_SYNTH;
      EESG_SYNTH:   next_state = EESG_HANDOFF;
      EESG_HANDOFF: next_state = EESG_RUN;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= EESG_RUN;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // remembers which event caused the exit, for the handoff step
  logic cause_smi;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cause_smi <= 1'b0;
    end else if (clk_en && state == EESG_RUN && exit_smi) begin
      cause_smi <= 1'b1;
    end else if (clk_en && state == EESG_RUN) begin
      cause_smi <= 1'b0;
    end
  end

  // save, synthesis and modified-state outputs
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      save_pulse            <= 1'b0;
      save_component_bitmap <= 64'h0000000000000000;
      save_present_mask     <= 64'h0000000000000000;
      save_wide_form        <= 1'b0;
      synth_pulse           <= 1'b0;
      synth_bitmap          <= 64'h0000000000000000;
      modified_bitmap       <= 64'h0000000000000000;
    end else if (clk_en) begin
      save_pulse  <= state == EESG_SAVE;
      synth_pulse <= state == EESG_SYNTH;
      if (state == EESG_SAVE) begin
        save_component_bitmap <= enc_mask;
        save_wide_form        <= enc_wide;
        // an untouched image is still initial, so its bits may read zero
        save_present_mask <= save_state_modified ? enc_mask
                             : 64'h0000000000000000;
      end
      if (state == EESG_SYNTH) begin
        synth_bitmap <= enc_mask;
      end
      if (op_valid && op_code == EESG_OP_RESUME && !resume_bad &&
          !ud_hit && state == EESG_RUN) begin
        modified_bitmap <= requested_feature_mask;
      end
    end
  end

  // handoff to management handler, monitor or reset flow
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mgmt_handler_go      <= 1'b0;
      ssm_interrupt_bit    <= 1'b0;
      monitor_exit         <= 1'b0;
      vm_exit              <= 1'b0;
      exit_enclave_flag    <= 1'b0;
      guest_enclave_flag   <= 1'b0;
      power_on_init        <= 1'b0;
      firmware_init        <= 1'b0;
      wait_for_startup     <= 1'b0;
      warm_restart_blocked <= 1'b0;
      startup_dropped      <= 1'b0;
    end else if (clk_en) begin
      mgmt_handler_go    <= 1'b0;
      monitor_exit       <= 1'b0;
      vm_exit            <= 1'b0;
      exit_enclave_flag  <= 1'b0;
      guest_enclave_flag <= 1'b0;
      power_on_init      <= 1'b0;
      firmware_init      <= 1'b0;
      wait_for_startup   <= wait_for_startup & !sync_b[2];
      warm_restart_blocked <= enclave_mode && sync_b[1] && vmx_root;
      startup_dropped      <= enclave_mode && sync_b[2];
      if (state == EESG_HANDOFF) begin
        if (cause_smi && !dual_monitor) begin
          mgmt_handler_go   <= 1'b1;
          ssm_interrupt_bit <= 1'b1;
        end else if (cause_smi) begin
          monitor_exit       <= 1'b1;
          exit_enclave_flag  <= 1'b1;
          guest_enclave_flag <= 1'b1;
        end else if (vmx_nonroot) begin
          vm_exit           <= 1'b1;
          exit_enclave_flag <= 1'b1;
        end else begin
          power_on_init    <= 1'b1;
          firmware_init    <= is_boot_core;
          wait_for_startup <= !is_boot_core;
        end
      end else if (mgmt_handler_go) begin
        ssm_interrupt_bit <= 1'b0;
      end
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  sequence s_exit_start;
    state == EESG_RUN && (exit_smi || exit_init) && clk_en;
  endsequence

  property p_exit_save;
    @(posedge ref_clk) disable iff (reset)
    s_exit_start ##1 clk_en |-> state == EESG_SAVE;
  endproperty
  a_exit_save: assert property (p_exit_save)
    else $error("async exit did not start saving");

  property p_restore_xcr;
    @(posedge ref_clk) disable iff (reset)
    (state == EESG_SYNTH && clk_en) |=>
      extended_control_reg == $past(saved_xcr) && !enclave_mode;
  endproperty
  a_restore_xcr: assert property (p_restore_xcr)
    else $error("control register not restored after exit");

  property p_ud_fault;
    @(posedge ref_clk) disable iff (reset)
    ud_hit && clk_en |=> fault == EESG_FAULT_UD;
  endproperty
  a_ud_fault: assert property (p_ud_fault)
    else $error("enclave op in management mode did not raise ud");

  property p_create_low;
    @(posedge ref_clk) disable iff (reset)
    clk_en && op_valid && op_code == EESG_OP_CREATE && !ud_hit &&
    state == EESG_RUN && requested_feature_mask[1:0] != 2'h3
      |=> fault == EESG_FAULT_GP && fault_code == 16'h0000;
  endproperty
  a_create_low: assert property (p_create_low)
    else $error("create with bad low mask bits did not fault");

  property p_entry_nofx;
    @(posedge ref_clk) disable iff (reset)
    clk_en && op_valid && op_code == EESG_OP_ENTER && !ud_hit &&
    state == EESG_RUN && !os_fx_save_enable
      |=> fault == EESG_FAULT_GP && $stable(extended_control_reg);
  endproperty
  a_entry_nofx: assert property (p_entry_nofx)
    else $error("entry with fx save off did not fault cleanly");

  property p_entry_swap;
    @(posedge ref_clk) disable iff (reset)
    clk_en && op_valid && op_code == EESG_OP_ENTER && !ud_hit &&
    state == EESG_RUN && !entry_bad
      |=> extended_control_reg == $past(requested_feature_mask) &&
          saved_xcr == $past(extended_control_reg) && enclave_mode;
  endproperty
  a_entry_swap: assert property (p_entry_swap)
    else $error("entry did not swap control register");

  property p_resume_fault;
    @(posedge ref_clk) disable iff (reset)
    clk_en && op_valid && op_code == EESG_OP_RESUME && !ud_hit &&
    state == EESG_RUN && area_bad |=> fault == EESG_FAULT_GP;
  endproperty
  a_resume_fault: assert property (p_resume_fault)
    else $error("resume with bad save area did not fault");

  property p_smi_bit;
    @(posedge ref_clk) disable iff (reset)
    clk_en && state == EESG_HANDOFF && cause_smi && !dual_monitor
      |=> ssm_interrupt_bit && mgmt_handler_go;
  endproperty
  a_smi_bit: assert property (p_smi_bit)
    else $error("management interrupt exit did not mark map bit");

  property p_save_mask;
    @(posedge ref_clk) disable iff (reset)
    clk_en && state == EESG_SAVE
      |=> (save_present_mask & ~save_component_bitmap) == '0;
  endproperty
  a_save_mask: assert property (p_save_mask)
    else $error("present bits set outside mask");
endmodule

// file: verification/eesg_guard_tb.sv
// self-checking bench for the enclave extended-state guard
`timescale 1ns/100ps
module eesg_guard_tb
  import eesg_pkg::*;
;
  // ***********************************************************
  // signals
  // ***********************************************************
  logic        ref_clk, reset, clk_en, op_valid, is_supervisor_insn;
  eesg_op_t    op_code;
  logic [63:0] requested_feature_mask, xcr_write_data;
  logic [31:0] misc_state_select, save_frame_size;
  logic        frame_small, xcr_load_bad, area_bad, save_support;
  logic        os_fx_save_enable, os_ext_save_enable, system_mgmt_mode;
  logic        dual_monitor, vmx_root, vmx_nonroot, is_boot_core;
  logic        xcr_write, save_state_modified;
  logic        async_system_mgmt_interrupt, async_warm_restart_signal;
  logic        async_startup_ipi;
  logic        op_done, enclave_mode, save_pulse, save_wide_form;
  eesg_fault_t fault, got_fault;
  logic [15:0] fault_code;
  logic [63:0] extended_control_reg, save_component_bitmap;
  logic [63:0] save_present_mask, synth_bitmap, modified_bitmap;
  logic [63:0] report_feature_mask;
  logic [31:0] report_misc_select;
  logic        synth_pulse, report_valid, mgmt_handler_go;
  logic        ssm_interrupt_bit, monitor_exit, vm_exit;
  logic        exit_enclave_flag, guest_enclave_flag, power_on_init;
  logic        firmware_init, wait_for_startup, warm_restart_blocked;
  logic        startup_dropped;
  int          fail_count, cmp_count, cycles;

  eesg_guard i_eesg_guard (.*);

  // ***********************************************************
  // clock, timeout and report
  // ***********************************************************
  // 20 MHz core clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // the whole sequence needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // ***********************************************************
  // access tasks, entered 2 ns after a rising edge
  // ***********************************************************
  // one op, held a single edge, then a bounded wait for op_done
  task automatic fop(input eesg_op_t code, input logic [63:0] m,
                     input eesg_fault_t exp);
    logic seen;
    seen = 1'b0;
    // one idle edge keeps back-to-back calls from rewriting op_valid
    @(posedge ref_clk);
    #2;
    op_code = code;
    requested_feature_mask = m;
    op_valid = 1'b1;
    for (int i = 0; i < 6 && !seen; i++) begin
      @(posedge ref_clk);
      #2;
      op_valid = 1'b0;
      if (op_done === 1'b1) begin
        seen = 1'b1;
        got_fault = fault;
      end
    end
    chk("op_done", 1, seen);
    if (seen)
      chk("fault", exp, got_fault);
  endtask

  // bounded wait for one of the event outputs
  task automatic wait_sig(input int sel, input string nm);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 12 && !hit; i++) begin
      @(posedge ref_clk);
      #2;
      case (sel)
        0: hit = (save_pulse === 1'b1);
        1: hit = (synth_pulse === 1'b1);
        2: hit = (mgmt_handler_go === 1'b1);
        3: hit = (monitor_exit === 1'b1);
        4: hit = (vm_exit === 1'b1);
        5: hit = (power_on_init === 1'b1);
        6: hit = (firmware_init === 1'b1);
        7: hit = (warm_restart_blocked === 1'b1);
        default: hit = (startup_dropped === 1'b1);
      endcase
    end
    chk(nm, 1, hit);
  endtask

  // control register write while outside the enclave
  task automatic wr_xcr(input logic [63:0] d);
    xcr_write = 1'b1;
    xcr_write_data = d;
    @(posedge ref_clk);
    #2;
    xcr_write = 1'b0;
    repeat (2) @(posedge ref_clk);
    #2;
    chk("xcr", d, extended_control_reg);
  endtask

  // ***********************************************************
  // main sequence
  // ***********************************************************
  // all inputs valued at time zero, reset held 6 cycles
  initial begin
    {reset, clk_en, op_valid, is_supervisor_insn} = 4'hC;
    op_code = EESG_OP_NONE;
    {requested_feature_mask, xcr_write_data} = '0;
    misc_state_select = 32'h0000005A;
    save_frame_size = 32'h00000010;
    {frame_small, xcr_load_bad, area_bad, save_support} = 4'h0;
    {os_fx_save_enable, os_ext_save_enable, system_mgmt_mode} = 3'h6;
    {dual_monitor, vmx_root, vmx_nonroot, is_boot_core} = 4'h0;
    {xcr_write, save_state_modified} = 2'h0;
    async_system_mgmt_interrupt = 1'b0;
    async_warm_restart_signal = 1'b0;
    async_startup_ipi = 1'b0;
    repeat (6) @(posedge ref_clk);
    #2;
    reset = 1'b0;
    chk("xcr", 64'h3, extended_control_reg);
    chk("enclave_mode", 0, enclave_mode);
    wr_xcr(64'hF);
    // a low clock enable must freeze the control register
    xcr_write_data = 64'h0000000000000007;
    {clk_en, xcr_write} = 2'h1;
    repeat (2) @(posedge ref_clk);
    #2;
    chk("xcr_frozen", 64'hF, extended_control_reg);
    {clk_en, xcr_write} = 2'h2;
    // create checks, first without save support
    fop(EESG_OP_CREATE, 64'h1, EESG_FAULT_GP);
    chk("fault_code", 0, fault_code);
    fop(EESG_OP_CREATE, 64'h7, EESG_FAULT_GP);
    save_frame_size = 32'h00000000;
    fop(EESG_OP_CREATE, 64'h3, EESG_FAULT_GP);
    save_frame_size = 32'h00000010;
    save_support = 1'b1;
    xcr_load_bad = 1'b1;
    fop(EESG_OP_CREATE, 64'h7, EESG_FAULT_GP);
    xcr_load_bad = 1'b0;
    fop(EESG_OP_CREATE, 64'h8000000000000007, EESG_FAULT_GP);
    frame_small = 1'b1;
    fop(EESG_OP_CREATE, 64'h7, EESG_FAULT_GP);
    frame_small = 1'b0;
    fop(EESG_OP_CREATE, 64'h7, EESG_FAULT_NONE);
    fop(EESG_OP_REPORT, 64'h7, EESG_FAULT_NONE);
    chk("rep_mask", 64'h7, report_feature_mask);
    chk("rep_valid", 1, report_valid);
    chk("rep_misc", 64'h5A, report_misc_select);
    // entry refusals leave the control register alone
    os_fx_save_enable = 1'b0;
    fop(EESG_OP_ENTER, 64'h7, EESG_FAULT_GP);
    os_fx_save_enable = 1'b1;
    os_ext_save_enable = 1'b0;
    fop(EESG_OP_ENTER, 64'h7, EESG_FAULT_GP);
    os_ext_save_enable = 1'b1;
    fop(EESG_OP_ENTER, 64'h1F, EESG_FAULT_GP);
    chk("xcr", 64'hF, extended_control_reg);
    chk("enclave_mode", 0, enclave_mode);
    fop(EESG_OP_ENTER, 64'h7, EESG_FAULT_NONE);
    chk("xcr", 64'h7, extended_control_reg);
    fop(EESG_OP_LEAVE, 64'h7, EESG_FAULT_NONE);
    chk("xcr", 64'hF, extended_control_reg);
    // management interrupt, plain treatment
    fop(EESG_OP_ENTER, 64'h7, EESG_FAULT_NONE);
    {async_system_mgmt_interrupt, save_state_modified} = 2'h3;
    wait_sig(0, "save_pulse");
    chk("save_bitmap", 64'h7, save_component_bitmap);
    chk("wide_form", 0, save_wide_form);
    chk("present_all", 64'h7, save_present_mask);
    chk("present", 0, save_present_mask & ~64'h7);
    wait_sig(1, "synth_pulse");
    chk("synth_bitmap", 64'h7, synth_bitmap);
    chk("xcr", 64'hF, extended_control_reg);
    wait_sig(2, "handler_go");
    chk("ssm_bit", 1, ssm_interrupt_bit);
    async_system_mgmt_interrupt = 1'b0;
    // resume refusals: bad save area, fx save off, mask not a subset of the control register
    area_bad = 1'b1;
    os_ext_save_enable = 1'b0;
    fop(EESG_OP_RESUME, 64'h3, EESG_FAULT_GP);
    {area_bad, os_ext_save_enable, os_fx_save_enable} = 3'h2;
    fop(EESG_OP_RESUME, 64'h7, EESG_FAULT_GP);
    os_fx_save_enable = 1'b1;
    fop(EESG_OP_RESUME, 64'h1F, EESG_FAULT_GP);
    chk("xcr", 64'hF, extended_control_reg);
    fop(EESG_OP_RESUME, 64'h7, EESG_FAULT_NONE);
    chk("xcr", 64'h7, extended_control_reg);
    chk("modified", 64'h7, modified_bitmap);
    // management interrupt under the dual monitor
    dual_monitor = 1'b1;
    async_system_mgmt_interrupt = 1'b1;
    wait_sig(3, "monitor_exit");
    chk("exit_flag", 1, exit_enclave_flag);
    chk("guest_flag", 1, guest_enclave_flag);
    {async_system_mgmt_interrupt, dual_monitor} = 2'h0;
    system_mgmt_mode = 1'b1;
    fop(EESG_OP_REPORT, 64'h7, EESG_FAULT_UD);
    fop(EESG_OP_CREATE, 64'h7, EESG_FAULT_UD);
    system_mgmt_mode = 1'b0;
    // warm restart in root, then non-root operation
    fop(EESG_OP_ENTER, 64'h7, EESG_FAULT_NONE);
    {vmx_root, async_warm_restart_signal} = 2'h3;
    wait_sig(7, "blocked");
    chk("enclave_mode", 1, enclave_mode);
    {vmx_root, vmx_nonroot} = 2'h1;
    wait_sig(4, "vm_exit");
    chk("exit_flag", 1, exit_enclave_flag);
    {vmx_nonroot, async_warm_restart_signal} = 2'h0;
    // startup interrupt inside the enclave is dropped
    fop(EESG_OP_ENTER, 64'h7, EESG_FAULT_NONE);
    async_startup_ipi = 1'b1;
    wait_sig(8, "dropped");
    chk("enclave_mode", 1, enclave_mode);
    {async_startup_ipi, is_boot_core} = 2'h1;
    async_warm_restart_signal = 1'b1;
    wait_sig(6, "firmware");
    {async_warm_restart_signal, is_boot_core} = 2'h0;
    // the warm restart exit has left the control register at its saved value F
    wr_xcr(64'hF);
    fop(EESG_OP_ENTER, 64'h7, EESG_FAULT_NONE);
    async_warm_restart_signal = 1'b1;
    wait_sig(5, "power_init");
    async_warm_restart_signal = 1'b0;
    repeat (3) @(posedge ref_clk);
    #2;
    chk("wait_startup", 1, wait_for_startup);
    chk("enclave_mode", 0, enclave_mode);
    // the startup interrupt releases the waiting core outside the enclave
    async_startup_ipi = 1'b1;
    repeat (3) @(posedge ref_clk);
    #2;
    chk("wait_startup", 0, wait_for_startup);
    chk("dropped", 0, startup_dropped);
    summarize();
  end
endmodule
